/* File: core/bdu_pkg.sv */
// Purpose: Shared types and constants for the BCD/real divide unit
// Assumes: Packed BCD, four digits per 16-bit word, low digit lowest
// Notes:   Opcodes and APB offsets are local to this unit
package bdu_pkg;
	localparam int BDU_DIGIT_W  = 4;
	localparam int BDU_WORD_W   = 16;
	localparam int BDU_DWORD_W  = 32;
	localparam int BDU_WDIGITS  = 4;
	localparam int BDU_DDIGITS  = 8;

	// APB register offsets
	localparam logic [7:0] BDU_OFF_CTRL   = 8'h00;
	localparam logic [7:0] BDU_OFF_OPA    = 8'h04;
	localparam logic [7:0] BDU_OFF_OPB    = 8'h08;
	localparam logic [7:0] BDU_OFF_ACC    = 8'h0C;
	localparam logic [7:0] BDU_OFF_STACK  = 8'h10;
	localparam logic [7:0] BDU_OFF_STATUS = 8'h14;
	localparam logic [7:0] BDU_OFF_MEMW   = 8'h18;

	// Control field positions
	localparam int BDU_CTRL_GO_B  = 0;
	localparam int BDU_CTRL_OP_LO = 4;
	localparam int BDU_CTRL_SRC_B = 8;
	localparam int BDU_CTRL_PTR_B = 9;
	localparam int BDU_CTRL_BAD_B = 10;

	// Status bit positions
	localparam int BDU_ST_OVF  = 0;
	localparam int BDU_ST_ZERO = 1;
	localparam int BDU_ST_NEG  = 2;
	localparam int BDU_ST_BPTR = 3;
	localparam int BDU_ST_FVAL = 4;
	localparam int BDU_ST_SGN  = 5;
	localparam int BDU_ST_UNF  = 6;
	localparam int BDU_ST_NBCD = 7;
	localparam int BDU_ST_BUSY = 8;

	localparam logic [31:0] BDU_ZERO32 = 32'h0000_0000;
	localparam logic [15:0] BDU_ZERO16 = 16'h0000;
	localparam logic [3:0]  BDU_NINE   = 4'h9;
	localparam logic [3:0]  BDU_ONE    = 4'h1;
	localparam logic [7:0]  BDU_EXP_MAX = 8'hFF;
	localparam logic [7:0]  BDU_EXP_BIAS = 8'h7F;

	typedef enum logic [2:0] {
		BDU_OP_DIV, BDU_OP_BCD_DIVIDE_DOUBLE, BDU_OP_REAL_DIVIDE, BDU_OP_INC, BDU_OP_DEC
	} bdu_op_t;

	typedef enum logic {BDU_SRC_MEM, BDU_SRC_CONST} bdu_src_t;

	typedef struct packed {
		logic ovf;
		logic zero;
		logic neg;
		logic bptr;
		logic fval;
		logic sgn;
		logic unf;
		logic nbcd;
	} bdu_flags_t;
endpackage : bdu_pkg

/* File: core/bdu_unit.sv */
// Purpose: APB-controlled BCD divide, real divide and BCD inc/dec datapath
// Assumes: Software writes operands, then CTRL with go bit set
// Notes:   BCD divides iterate one binary quotient bit per clock cycle; real divide is combinational
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module bdu_unit
	import bdu_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Status
	output logic             busy_o
);
	typedef enum {ST_IDLE, ST_DIV, ST_DONE} bdu_state_t;
	// Assertion clock and reset
	default clocking bdu_cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	// Check every nibble for a decimal digit
	function automatic logic bcd_bad(input logic [31:0] v, input int n);
		logic b;
		b = 1'b0;
		for (int i = 0; i < n; i++) begin
			b = b | (v[i*BDU_DIGIT_W +: BDU_DIGIT_W] > BDU_NINE);
		end
		return b;
	endfunction : bcd_bad
	// BCD to binary
	function automatic logic [31:0] bcd2bin(input logic [31:0] v);
		logic [31:0] r;
		r = BDU_ZERO32;
		for (int i = BDU_DDIGITS - 1; i >= 0; i--) begin
			r = 32'((r * 10) + 32'(v[i*BDU_DIGIT_W +: BDU_DIGIT_W]));
		end
		return r;
	endfunction : bcd2bin

	// Binary to BCD by double dabble
	function automatic logic [31:0] bin2bcd(input logic [31:0] v);
		logic [31:0] r;
		r = BDU_ZERO32;
		for (int i = BDU_DWORD_W - 1; i >= 0; i--) begin
			for (int d = 0; d < BDU_DDIGITS; d++) begin
				r[d*4 +: 4] = (r[d*4 +: 4] > 4'h4) ?
				              4'(r[d*4 +: 4] + 4'h3) : r[d*4 +: 4];
			end
			r = {r[30:0], v[i]};
		end
		return r;
	endfunction : bin2bcd
	// Add or subtract one on a packed BCD word, wrapping
	function automatic logic [15:0] bcd_step(input logic [15:0] v,
	                                         input logic up);
		logic [15:0] r;
		logic        c;
		r = v;
		c = 1'b1;
		for (int d = 0; d < BDU_WDIGITS; d++) begin
			if (c) begin
				c = (v[d*4 +: 4] == (up ? BDU_NINE : 4'h0));
				r[d*4 +: 4] = c ? (up ? 4'h0 : BDU_NINE) :
				              (up ? 4'(v[d*4 +: 4] + BDU_ONE) :
				                    4'(v[d*4 +: 4] - BDU_ONE));
			end
		end
		return r;
	endfunction : bcd_step
	// Registers
	bdu_state_t  state_q, state_d;
	bdu_op_t     op_q, op_d;
	logic [31:0] opa_q, opa_d;
	logic [31:0] opb_q, opb_d;
	logic [31:0] acc_q, acc_d;
	logic [31:0] stk_q, stk_d;
	logic [15:0] memw_q, memw_d;
	logic [31:0] quo_q, quo_d;
	logic [31:0] rem_q, rem_d;
	logic [31:0] den_q, den_d;
	logic [5:0]  cnt_q, cnt_d;
	bdu_flags_t  flg_q, flg_d;
	logic [31:0] prdata_d;
	logic        pready_d, pslverr_d;

	// Real divide combinational result
	logic [31:0] fdiv;
	logic        f_unf, f_nreal;

	// Single precision divide, truncating mantissa
	always_comb begin
		logic [47:0] mq;
		logic [9:0]  ex;
		logic        sa, sb;
		mq = 48'h0000_0000_0000;
		ex = 10'h000;
		sa = acc_q[31];
		sb = opb_q[31];
		fdiv = BDU_ZERO32;
		f_unf = 1'b0;
		f_nreal = (acc_q[30:23] == BDU_EXP_MAX) ||
		          (opb_q[30:23] == BDU_EXP_MAX) ||
		          (opb_q[30:23] == 8'h00);
		if (!f_nreal && acc_q[30:23] != 8'h00) begin
			mq = {1'b1, acc_q[22:0], 24'h00_0000} / {24'h00_0000, 1'b1, opb_q[22:0]};
			ex = 10'({2'b00, acc_q[30:23]} - {2'b00, opb_q[30:23]} +
			         {2'b00, BDU_EXP_BIAS});
			if (!mq[24]) begin
				mq = {mq[46:0], 1'b0};
				ex = 10'(ex - 10'h001);
			end
			if (ex[9] || ex == 10'h000) begin
				f_unf = 1'b1;
				fdiv = {sa ^ sb, 31'h0000_0000};
			end else if (ex >= 10'h0FF) begin
				f_nreal = 1'b1;
			end else begin
				fdiv = {sa ^ sb, ex[7:0], mq[23:1]};
			end
		end
	end

	// Sequencer and datapath next state
	always_comb begin
		logic [31:0] t;
		logic        rd;
		state_d = state_q;
		op_d = op_q;
		opa_d = opa_q;
		opb_d = opb_q;
		acc_d = acc_q;
		stk_d = stk_q;
		memw_d = memw_q;
		quo_d = quo_q;
		rem_d = rem_q;
		den_d = den_q;
		cnt_d = cnt_q;
		flg_d = flg_q;
		prdata_d = BDU_ZERO32;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		t = BDU_ZERO32;
		rd = psel_i && penable_i && !pready_o;
		case (state_q)
			ST_IDLE: begin
			end
			ST_DIV: begin
				// Restoring binary division, one bit per cycle
				t = {rem_q[30:0], quo_q[31]};
				quo_d = {quo_q[30:0], 1'b0};
				if (t >= den_q) begin
					t = 32'(t - den_q);
					quo_d[0] = 1'b1;
				end
				rem_d = t;
				cnt_d = 6'(cnt_q - 6'h01);
				if (cnt_q == 6'h01) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				acc_d = bin2bcd(quo_q);
				stk_d = bin2bcd(rem_q);
				flg_d.zero = (quo_q == BDU_ZERO32);
				flg_d.neg = 1'b0;
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		// APB access, one wait state
		if (rd) begin
			pready_d = 1'b1;
			if (paddr_i == BDU_OFF_CTRL) begin
				prdata_d = {23'h00_0000, 1'(op_q), 8'h00};
			end else if (paddr_i == BDU_OFF_OPA) begin
				prdata_d = opa_q;
			end else if (paddr_i == BDU_OFF_OPB) begin
				prdata_d = opb_q;
			end else if (paddr_i == BDU_OFF_ACC) begin
				prdata_d = acc_q;
			end else if (paddr_i == BDU_OFF_STACK) begin
				prdata_d = stk_q;
			end else if (paddr_i == BDU_OFF_STATUS) begin
				prdata_d = {23'h00_0000, state_q != ST_IDLE,
				            flg_q.nbcd, flg_q.unf, flg_q.sgn, flg_q.fval,
				            flg_q.bptr, flg_q.neg, flg_q.zero, flg_q.ovf};
			end else if (paddr_i == BDU_OFF_MEMW) begin
				prdata_d = {16'h0000, memw_q};
			end else begin
				pslverr_d = 1'b1;
			end
			if (pwrite_i) begin
				prdata_d = BDU_ZERO32;
				if (state_q != ST_IDLE) begin
					pslverr_d = 1'b1;
				end else if (paddr_i == BDU_OFF_OPA) begin
					opa_d = pwdata_i;
				end else if (paddr_i == BDU_OFF_OPB) begin
					opb_d = pwdata_i;
				end else if (paddr_i == BDU_OFF_ACC) begin
					acc_d = pwdata_i;
				end else if (paddr_i == BDU_OFF_MEMW) begin
					memw_d = pwdata_i[15:0];
				end else if (paddr_i == BDU_OFF_CTRL &&
				             pwdata_i[BDU_CTRL_GO_B]) begin
					op_d = bdu_op_t'(pwdata_i[BDU_CTRL_OP_LO +: 3]);
					flg_d.bptr = pwdata_i[BDU_CTRL_PTR_B] &&
					             pwdata_i[BDU_CTRL_BAD_B];
					case (op_d)
						BDU_OP_DIV, BDU_OP_BCD_DIVIDE_DOUBLE: begin
							t = (op_d == BDU_OP_DIV) ?
							    {16'h0000, opb_q[15:0]} : opb_q;
							flg_d.nbcd = bcd_bad(acc_q, BDU_DDIGITS) ||
							             bcd_bad(t, BDU_DDIGITS);
							flg_d.ovf = (t == BDU_ZERO32) ||
							   (op_d == BDU_OP_BCD_DIVIDE_DOUBLE &&
							    pwdata_i[BDU_CTRL_SRC_B]);
							if (!flg_d.nbcd && !flg_d.ovf && !flg_d.bptr) begin
								quo_d = bcd2bin(acc_q);
								den_d = bcd2bin(t);
								rem_d = BDU_ZERO32;
								cnt_d = 6'(BDU_DWORD_W);
								state_d = ST_DIV;
							end
						end
						BDU_OP_REAL_DIVIDE: begin
							flg_d.nbcd = f_nreal;
							flg_d.unf = f_unf;
							flg_d.sgn = 1'b0;
							if (!f_nreal && !flg_d.bptr) begin
								acc_d = fdiv;
							end
							t = (!f_nreal && !flg_d.bptr) ? fdiv : acc_q;
							flg_d.zero = (t[30:0] == 31'h0000_0000);
							flg_d.neg = t[31];
							flg_d.fval = (t[30:23] != BDU_EXP_MAX);
						end
						BDU_OP_INC, BDU_OP_DEC: begin
							flg_d.nbcd = bcd_bad({16'h0000, memw_q},
							                     BDU_WDIGITS);
							if (!flg_d.nbcd && !flg_d.bptr) begin
								memw_d = bcd_step(memw_q,
								         op_d == BDU_OP_INC);
							end
							flg_d.zero = (memw_d == BDU_ZERO16);
						end
						default: flg_d.ovf = 1'b0;
					endcase
				end
			end
		end
	end

	// Register update; flags persist until the next op touches them
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			op_q <= BDU_OP_DIV;
			{opa_q, opb_q, acc_q, stk_q, memw_q, quo_q, rem_q, den_q, cnt_q,
			 flg_q, prdata_o, pready_o, pslverr_o, busy_o} <= '0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			{opa_q, opb_q, acc_q, stk_q, memw_q, quo_q, rem_q, den_q,
			 cnt_q} <= {opa_d, opb_d, acc_d, stk_d, memw_d, quo_d, rem_d,
			            den_d, cnt_d};
			flg_q <= flg_d;
			prdata_o <= prdata_d;
			pready_o <= pready_d;
			pslverr_o <= pslverr_d;
			busy_o <= (state_d != ST_IDLE);
		end
	end

	// Divide completes a fixed number of cycles after launch
	a_div_latency: assert property (
		$rose(state_q == ST_DIV) |-> ##32 (state_q == ST_DONE))
		else $error("divide did not finish in 32 steps");
	// Zero flag follows accumulator after a divide
	a_div_zero: assert property (
		(state_q == ST_DONE) |=> (flg_q.zero == (acc_q == BDU_ZERO32)))
		else $error("zero flag mismatch after divide");
	// Remainder lands in stack and is below divisor
	a_rem_stack: assert property (
		(state_q == ST_DONE) |=> (stk_q == bin2bcd($past(rem_q))) &&
		                         ($past(rem_q) < $past(den_q)))
		else $error("remainder wrong");
	// Divide result is never negative
	a_div_neg: assert property (
		(state_q == ST_DONE) |=> !flg_q.neg)
		else $error("negative after BCD divide");
	// Divide only starts with a nonzero divisor
	a_no_zero_div: assert property (
		(state_q == ST_DIV) |-> (den_q != BDU_ZERO32))
		else $error("division by zero started");
	// Flags hold while idle with no bus write
	a_flag_hold: assert property (
		(state_q == ST_IDLE && !(psel_i && penable_i && pwrite_i))
		|=> $stable(flg_q))
		else $error("flags changed without an operation");
	// Memory word only moves through bus write or inc/dec
	a_memw_hold: assert property (
		!(psel_i && penable_i && pwrite_i) |=> $stable(memw_q))
		else $error("memory word changed unexpectedly");
	// Bad pointer on a real divide start leaves the accumulator alone
	a_bptr_block: assert property (
		(psel_i && penable_i && pwrite_i && !pready_o && flg_d.bptr &&
		 paddr_i == BDU_OFF_CTRL && op_d == BDU_OP_REAL_DIVIDE)
		|=> $stable(acc_q))
		else $error("bad pointer still updated accumulator");
	// Every access answered one cycle after access phase opens
	a_apb_ready: assert property (
		(psel_i && penable_i && !pready_o) |=> pready_o)
		else $error("APB access not answered");
endmodule : bdu_unit

/* File: tb/bdu_seq_model.sv */
// Purpose: Sequencer model issuing unit requests over APB
// Assumes: Unit answers with a one-cycle pready pulse
// Notes:   Address and write data are inverted after release so stale values never match
`timescale 1ns/1ps
module bdu_seq_model (
	// Clock
	input  wire logic        core_clk_i,
	// APB master side
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [7:0]       paddr_o,
	output logic [31:0]      pwdata_o,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i
);
	// Idle bus at time zero
	initial begin
		psel_o    = 1'b0;
		penable_o = 1'b0;
		pwrite_o  = 1'b0;
		paddr_o   = 8'h00;
		pwdata_o  = 32'h0000_0000;
	end

	// One request per call, held until pready is sampled
	task automatic apb_xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge core_clk_i);
		psel_o    <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o  <= w;
		paddr_o   <= a;
		pwdata_o  <= d;
		@(posedge core_clk_i);
		penable_o <= 1'b1;
		do begin
			@(posedge core_clk_i);
		end while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o    <= 1'b0;
		penable_o <= 1'b0;
		paddr_o   <= ~a;
		pwdata_o  <= ~d;
	endtask : apb_xfer
endmodule : bdu_seq_model

/* File: tb/bdu_unit_tb.sv */
// Purpose: Self-checking bench for the divide and inc/dec unit
// Assumes: Register map and op codes of the unit package
// Notes:   Constant divisors stay within 1 to 9999
`timescale 1ns/1ps
module bdu_unit_tb;
	import bdu_pkg::*;
	logic        core_clk_i;
	logic        reset_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        busy_o;
	int          n_mismatch;
	int          samples_checked;

	// Unit under test
	bdu_unit uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o));

	// Sequencer model driving the bus
	bdu_seq_model u_seq (.core_clk_i(core_clk_i), .psel_o(psel_i),
		.penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
		.pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o),
		.pslverr_i(pslverr_o));

	// 10 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	// Verdict and end of run
	task automatic report_and_stop();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop

	// Word compare
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : cmp_word

	// Error response compare
	task automatic cmp_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit

	// Register write with expected error response
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic xe);
		logic [31:0] r;
		logic        e;
		u_seq.apb_xfer(1'b1, a, d, r, e);
		cmp_bit(e, xe);
	endtask : wr

	// Register read, masked compare
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m, input logic xe);
		logic [31:0] r;
		logic        e;
		u_seq.apb_xfer(1'b0, a, 32'h0000_0000, r, e);
		cmp_word(r & m, x & m);
		cmp_bit(e, xe);
	endtask : rd

	// Wait for busy to drop; only the watchdog ends a hang
	task automatic wait_idle();
		@(posedge core_clk_i);
		while (busy_o !== 1'b0) begin
			@(posedge core_clk_i);
		end
	endtask : wait_idle

	// Start an op and wait for busy to drop
	task automatic run(input bdu_op_t op, input logic [2:0] f);
		wr(BDU_OFF_CTRL, {21'h0, f, 1'b0, op, 3'b000, 1'b1}, 1'b0);
		wait_idle();
	endtask : run

	// Watchdog
	initial begin
		repeat (20000) @(posedge core_clk_i);
		n_mismatch++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		n_mismatch = 0;
		samples_checked = 0;
		reset_i = 1'b1;
		repeat (16) @(posedge core_clk_i);
		reset_i <= 1'b0;
		rd(BDU_OFF_STATUS, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_ACC, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
		// Single divide with a write refused while busy
		wr(BDU_OFF_ACC, 32'h0000_0100, 1'b0);
		wr(BDU_OFF_OPB, 32'h0000_0007, 1'b0);
		wr(BDU_OFF_CTRL, 32'h0000_0001, 1'b0);
		wr(BDU_OFF_ACC, 32'h0000_5555, 1'b1);
		wr(BDU_OFF_CTRL, 32'h0000_0031, 1'b1);
		rd(BDU_OFF_STATUS, 32'h0000_0100, 32'h0000_0100, 1'b0);
		cmp_bit(busy_o, 1'b1);
		wait_idle();
		rd(BDU_OFF_ACC, 32'h0000_0014, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STACK, 32'h0000_0002, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STATUS, 32'h0000_0000, 32'h0000_0187, 1'b0);
		wr(BDU_OFF_ACC, 32'h0000_0003, 1'b0);
		run(BDU_OP_DIV, 3'b000);
		rd(BDU_OFF_ACC, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STACK, 32'h0000_0003, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STATUS, 32'h0000_0002, 32'h0000_0087, 1'b0);
		// Constant divisor at its upper bound
		wr(BDU_OFF_ACC, 32'h0000_9999, 1'b0);
		wr(BDU_OFF_OPB, 32'h0000_9999, 1'b0);
		run(BDU_OP_DIV, 3'b001);
		rd(BDU_OFF_ACC, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STACK, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
		wr(BDU_OFF_OPB, 32'h0000_0000, 1'b0);
		run(BDU_OP_DIV, 3'b000);
		rd(BDU_OFF_STATUS, 32'h0000_0001, 32'h0000_0001, 1'b0);
		wr(BDU_OFF_OPB, 32'h0000_000A, 1'b0);
		run(BDU_OP_DIV, 3'b000);
		rd(BDU_OFF_STATUS, 32'h0000_0080, 32'h0000_0080, 1'b0);
		rd(BDU_OFF_ACC, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0);
		// Double divide through a valid pointer
		wr(BDU_OFF_ACC, 32'h1234_5678, 1'b0);
		wr(BDU_OFF_OPB, 32'h0000_0100, 1'b0);
		run(BDU_OP_BCD_DIVIDE_DOUBLE, 3'b010);
		rd(BDU_OFF_ACC, 32'h0012_3456, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STACK, 32'h0000_0078, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STATUS, 32'h0000_0000, 32'h0000_008F, 1'b0);
		run(BDU_OP_BCD_DIVIDE_DOUBLE, 3'b110);
		rd(BDU_OFF_STATUS, 32'h0000_0008, 32'h0000_0008, 1'b0);
		rd(BDU_OFF_ACC, 32'h0012_3456, 32'hFFFF_FFFF, 1'b0);
		run(BDU_OP_BCD_DIVIDE_DOUBLE, 3'b001);
		rd(BDU_OFF_STATUS, 32'h0000_0001, 32'h0000_0001, 1'b0);
		// Increment and decrement with wrap
		wr(BDU_OFF_MEMW, 32'h0000_9999, 1'b0);
		run(BDU_OP_INC, 3'b000);
		rd(BDU_OFF_MEMW, 32'h0000_0000, 32'h0000_FFFF, 1'b0);
		rd(BDU_OFF_STATUS, 32'h0000_0003, 32'h0000_0083, 1'b0);
		run(BDU_OP_DEC, 3'b000);
		rd(BDU_OFF_MEMW, 32'h0000_9999, 32'h0000_FFFF, 1'b0);
		rd(BDU_OFF_STATUS, 32'h0000_0000, 32'h0000_0002, 1'b0);
		wr(BDU_OFF_MEMW, 32'h0000_0100, 1'b0);
		run(BDU_OP_DEC, 3'b000);
		rd(BDU_OFF_MEMW, 32'h0000_0099, 32'h0000_FFFF, 1'b0);
		// Real divide with a negative result
		wr(BDU_OFF_ACC, 32'hC0C0_0000, 1'b0);
		wr(BDU_OFF_OPB, 32'h4000_0000, 1'b0);
		run(BDU_OP_REAL_DIVIDE, 3'b000);
		rd(BDU_OFF_ACC, 32'hC040_0000, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STATUS, 32'h0000_0014, 32'h0000_00FE, 1'b0);
		// Bad pointer keeps the accumulator, then an underflowing quotient
		run(BDU_OP_REAL_DIVIDE, 3'b110);
		rd(BDU_OFF_STATUS, 32'h0000_0008, 32'h0000_0008, 1'b0);
		rd(BDU_OFF_ACC, 32'hC040_0000, 32'hFFFF_FFFF, 1'b0);
		wr(BDU_OFF_ACC, 32'h0080_0000, 1'b0);
		run(BDU_OP_REAL_DIVIDE, 3'b000);
		rd(BDU_OFF_ACC, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
		rd(BDU_OFF_STATUS, 32'h0000_0052, 32'h0000_00FE, 1'b0);
		wr(BDU_OFF_OPB, 32'h0000_0000, 1'b0);
		run(BDU_OP_REAL_DIVIDE, 3'b000);
		rd(BDU_OFF_STATUS, 32'h0000_0080, 32'h0000_0080, 1'b0);
		// Unmapped address
		rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
		report_and_stop();
	end
endmodule : bdu_unit_tb
